// File: pkg/csp_pkg.sv
// Shared constants and types for the clocked serial port.
`default_nettype none

package csp_pkg;

  // ---------------------------------------------------------------
  // Register map in I/O space
  // ---------------------------------------------------------------
  localparam logic [7:0] CSP_CTRL_ADDR = 8'h0a;
  localparam logic [7:0] CSP_DATA_ADDR = 8'h0b;

  // ---------------------------------------------------------------
  // Control/status field positions and reset values
  // ---------------------------------------------------------------
  localparam int CSP_END_FLAG_BIT = 7;
  localparam int CSP_EIE_BIT = 6;
  localparam int CSP_RX_GO_BIT = 5;
  localparam int CSP_TX_GO_BIT = 4;
  localparam int CSP_SPEED_LSB = 0;
  localparam int CSP_SPEED_MSB = 2;
  localparam logic [2:0] CSP_SPEED_RESET = 3'h7;
  localparam logic [2:0] CSP_SPEED_EXTERNAL = 3'h7;
  localparam logic CSP_FLAG_RESET = 1'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Smallest divide ratio in system clocks; each code step doubles it.
  localparam int CSP_BASE_DIVIDE = 20;
  localparam logic [10:0] CSP_HALF_BASE = 11'(CSP_BASE_DIVIDE / 2);
  localparam logic [3:0] CSP_BITS_PER_BYTE = 4'h8;
  localparam logic CSP_SCLK_IDLE = 1'h1;
  localparam logic CSP_SOUT_IDLE = 1'h1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } csp_io_req_type;

  typedef struct packed {
    logic end_flag;
    logic end_irq_enable;
    logic rx_go;
    logic transmit_go;
    logic [2:0] speed_select;
  } csp_ctrl_type;

  typedef enum logic [1:0] {
    CSP_IDLE = 2'b01,
    CSP_SHIFT = 2'b10
  } csp_state_type;

endpackage

`default_nettype wire

// File: logic/csp_clk_div.sv
// Internal serial clock generator dividing the system clock.
`timescale 1ns/10ps
`default_nettype none

module csp_clk_div (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic [2:0] speed_i,
  // Generated clock and edge pulses
  output logic sclk_o,
  output logic rise_o,
  output logic fall_o
);

  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic sclk_q;
  logic sclk_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;
  logic [10:0] half_len;

  // Half period is ten clocks shifted up by the speed code.
  assign half_len = 11'(csp_pkg::CSP_HALF_BASE << speed_i);

  always_comb
  begin
    cnt_d = cnt_q;
    sclk_d = sclk_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (!run_i)
    begin
      cnt_d = '0;
      sclk_d = csp_pkg::CSP_SCLK_IDLE;
    end
    else if (cnt_q == half_len - 11'h001)
    begin
      cnt_d = '0;
      sclk_d = ~sclk_q;
      rise_d = ~sclk_q;
      fall_d = sclk_q;
    end
    else
    begin
      cnt_d = cnt_q + 11'h001;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      sclk_q <= csp_pkg::CSP_SCLK_IDLE;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sclk_q <= sclk_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign sclk_o = sclk_q;
  assign rise_o = rise_q;
  assign fall_o = fall_q;

endmodule

`default_nettype wire

// File: logic/csp_serial_port.sv
// Clocked full-duplex serial port with control/status and shift data registers.
`timescale 1ns/10ps
`default_nettype none

module csp_serial_port (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // CPU I/O access
  input wire csp_pkg::csp_io_req_type io_req_i,
  output logic [7:0] io_rdata_o,
  output logic irq_o,
  // Serial clock pin
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  // Serial data pins
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  csp_pkg::csp_ctrl_type ctrl_q;
  csp_pkg::csp_ctrl_type ctrl_d;
  csp_pkg::csp_state_type state_q;
  csp_pkg::csp_state_type state_d;
  logic [7:0] shift_data_byte_q;
  logic [7:0] shift_data_byte_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic sout_q;
  logic sout_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic irq_q;
  logic irq_d;
  logic clk_oe_q;
  logic clk_oe_d;
  logic ext_q;
  logic ext_prev_q;

  logic ctrl_wr;
  logic data_wr;
  logic ctrl_rd;
  logic data_rd;
  logic internal_mode;
  logic run_internal;
  logic int_sclk;
  logic int_rise;
  logic int_fall;
  logic bit_rise;
  logic bit_fall;
  logic active;

  assign ctrl_wr = io_req_i.wr && (io_req_i.addr == csp_pkg::CSP_CTRL_ADDR);
  assign data_wr = io_req_i.wr && (io_req_i.addr == csp_pkg::CSP_DATA_ADDR);
  assign ctrl_rd = io_req_i.rd && (io_req_i.addr == csp_pkg::CSP_CTRL_ADDR);
  assign data_rd = io_req_i.rd && (io_req_i.addr == csp_pkg::CSP_DATA_ADDR);
  assign active = ctrl_q.transmit_go || ctrl_q.rx_go;
  assign internal_mode = (ctrl_q.speed_select != csp_pkg::CSP_SPEED_EXTERNAL);
  assign run_internal = internal_mode && active && (state_q == csp_pkg::CSP_SHIFT);

  // ---------------------------------------------------------------
  // Serial clock sources
  // ---------------------------------------------------------------
  // divide ratio select
  csp_clk_div u_clk_div (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run_internal),
    .speed_i(ctrl_q.speed_select),
    .sclk_o(int_sclk),
    .rise_o(int_rise),
    .fall_o(int_fall)
  );

  // External clock is assumed slower than divide-by-20, so a plain edge detect suffices.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_q <= csp_pkg::CSP_SCLK_IDLE;
      ext_prev_q <= csp_pkg::CSP_SCLK_IDLE;
    end
    else
    begin
      ext_q <= serial_clock_pin_i;
      ext_prev_q <= ext_q;
    end
  end

  assign bit_rise = internal_mode ? int_rise : (ext_q && !ext_prev_q);
  assign bit_fall = internal_mode ? int_fall : (!ext_q && ext_prev_q);

  // ---------------------------------------------------------------
  // Control, shifter and read data
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    shift_data_byte_d = shift_data_byte_q;
    bit_cnt_d = bit_cnt_q;
    sout_d = sout_q;
    rdata_d = '0;

    if (state_q == csp_pkg::CSP_SHIFT && bit_rise)
    begin
      shift_data_byte_d = {serial_in_pin_i, shift_data_byte_q[7:1]};
      bit_cnt_d = bit_cnt_q + 4'h1;
      if (bit_cnt_q == csp_pkg::CSP_BITS_PER_BYTE - 4'h1)
      begin
        ctrl_d.transmit_go = 1'b0;
        ctrl_d.rx_go = 1'b0;
        state_d = csp_pkg::CSP_IDLE;
      end
    end
    if (state_q == csp_pkg::CSP_SHIFT && bit_fall && ctrl_q.transmit_go)
    begin
      sout_d = shift_data_byte_q[0];
    end

    if (data_wr)
    begin
      shift_data_byte_d = io_req_i.wdata;
    end

    if (ctrl_wr)
    begin
      ctrl_d.end_irq_enable = io_req_i.wdata[csp_pkg::CSP_EIE_BIT];
      ctrl_d.rx_go = io_req_i.wdata[csp_pkg::CSP_RX_GO_BIT];
      ctrl_d.transmit_go = io_req_i.wdata[csp_pkg::CSP_TX_GO_BIT];
      ctrl_d.speed_select = io_req_i.wdata[csp_pkg::CSP_SPEED_MSB:csp_pkg::CSP_SPEED_LSB];
      if (!ctrl_d.rx_go && !ctrl_d.transmit_go)
      begin
        state_d = csp_pkg::CSP_IDLE;
        sout_d = csp_pkg::CSP_SOUT_IDLE;
      end
      else if (!active)
      begin
        state_d = csp_pkg::CSP_SHIFT;
        bit_cnt_d = '0;
        // First bit is presented before the first clock edge.
        sout_d = ctrl_d.transmit_go ? shift_data_byte_d[0] : csp_pkg::CSP_SOUT_IDLE;
      end
    end

    if (data_wr || data_rd)
    begin
      ctrl_d.end_flag = 1'b0;
    end
    // completion sets end flag; a set in the same cycle as a clear wins.
    if (state_q == csp_pkg::CSP_SHIFT && bit_rise && bit_cnt_q == csp_pkg::CSP_BITS_PER_BYTE - 4'h1)
    begin
      ctrl_d.end_flag = 1'b1;
    end

    if (ctrl_rd)
    begin
      rdata_d = {ctrl_q.end_flag, ctrl_q.end_irq_enable, ctrl_q.rx_go, ctrl_q.transmit_go, 1'b0,
                 ctrl_q.speed_select};
    end
    else if (data_rd)
    begin
      rdata_d = shift_data_byte_q;
    end

    irq_d = ctrl_d.end_flag && ctrl_d.end_irq_enable;
    clk_oe_d = (ctrl_d.speed_select != csp_pkg::CSP_SPEED_EXTERNAL);
  end

  // reset values; the shift data byte is kept across reset.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q.end_flag <= csp_pkg::CSP_FLAG_RESET;
      ctrl_q.end_irq_enable <= csp_pkg::CSP_FLAG_RESET;
      ctrl_q.rx_go <= csp_pkg::CSP_FLAG_RESET;
      ctrl_q.transmit_go <= csp_pkg::CSP_FLAG_RESET;
      ctrl_q.speed_select <= csp_pkg::CSP_SPEED_RESET;
      state_q <= csp_pkg::CSP_IDLE;
      bit_cnt_q <= '0;
      sout_q <= csp_pkg::CSP_SOUT_IDLE;
      rdata_q <= '0;
      irq_q <= 1'b0;
      clk_oe_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      sout_q <= sout_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      clk_oe_q <= clk_oe_d;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_n_i)
    begin
      shift_data_byte_q <= shift_data_byte_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign io_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign serial_out_pin_o = sout_q;
  assign serial_clock_pin_o = int_sclk;
  assign serial_clock_pin_oe_o = clk_oe_q;

endmodule

`default_nettype wire

// File: test/csp_serial_port_asserts.sv
// Checker for the clocked serial port, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module csp_serial_port_asserts (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire csp_pkg::csp_io_req_type io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic irq_o,
  input wire logic serial_clock_pin_i,
  input wire logic serial_clock_pin_o,
  input wire logic serial_clock_pin_oe_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic ctl_wr;
  logic [2:0] spd_q, spd_d;
  logic [10:0] cnt_q, cnt_d;
  logic [3:0] rise_q, rise_d;
  logic prev_q, valid_q, valid_d;
  assign ctl_wr = io_req_i.wr && io_req_i.addr == csp_pkg::CSP_CTRL_ADDR;
  always_comb
  begin
    spd_d = ctl_wr ? io_req_i.wdata[2:0] : spd_q;
    cnt_d = (serial_clock_pin_o != prev_q) ? 11'h001 : cnt_q + 11'h001;
    valid_d = !ctl_wr && (valid_q || serial_clock_pin_o != prev_q);
    rise_d = ctl_wr ? 4'h0 : rise_q + 4'(serial_clock_pin_o && !prev_q);
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      spd_q <= 3'h7;
      cnt_q <= 11'h000;
      rise_q <= 4'h0;
      prev_q <= 1'h1;
      valid_q <= 1'h0;
    end
    else
    begin
      spd_q <= spd_d;
      cnt_q <= cnt_d;
      rise_q <= rise_d;
      prev_q <= serial_clock_pin_o;
      valid_q <= valid_d;
    end
  end
  sequence s_stop;
    ctl_wr && io_req_i.wdata[5:4] == 2'h0;
  endsequence
  a_rdata_rest: assert property (!io_req_i.rd |=> io_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property (io_req_i.rd && io_req_i.addr > csp_pkg::CSP_DATA_ADDR |=> io_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  a_pin_direction: assert property (ctl_wr |=> serial_clock_pin_oe_o == ($past(io_req_i.wdata[2:0]) != 3'h7))
    else $error("clock pin direction does not follow speed");
  a_reset_values: assert property ($rose(rst_n_i) |-> !serial_clock_pin_oe_o && serial_out_pin_o && !irq_o)
    else $error("pins not at reset state");
  a_abort_out_high: assert property (s_stop |=> serial_out_pin_o)
    else $error("data out not idle after stop");
  a_clock_stops: assert property (s_stop |=> ##2 $stable(serial_clock_pin_o) [*8])
    else $error("serial clock runs after stop");
  a_half_period: assert property (valid_q && serial_clock_pin_o != prev_q |-> cnt_q == (csp_pkg::CSP_HALF_BASE << spd_q))
    else $error("serial clock half period wrong");
  a_end_after_eight: assert property ($rose(irq_o) && serial_clock_pin_oe_o |-> rise_q == 4'h8)
    else $error("end not after eight clock rises");
  a_access_clears: assert property (irq_o && (io_req_i.wr || io_req_i.rd) && io_req_i.addr == 8'h0b |=> !irq_o)
    else $error("data access did not clear request");
endmodule
bind csp_serial_port csp_serial_port_asserts i_asserts (.ref_clk_i, .rst_n_i, .io_req_i, .io_rdata_o, .irq_o,
  .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe_o, .serial_in_pin_i, .serial_out_pin_o);
`default_nettype wire

// File: test/csp_peer_model.sv
// Behavioural peer device on the far end of the serial link.
`timescale 1ns/10ps
`default_nettype none
module csp_peer_model (
  // Bench control
  input wire logic clear_i,
  input wire logic [7:0] tx_byte_i,
  // Serial wires
  input wire logic sclk_i,
  input wire logic dout_i,
  output logic din_o,
  // Captured byte
  output logic [7:0] rx_byte_o
);
  logic [3:0] rises = 4'h0;
  logic [3:0] idx = 4'h0;
  always @(posedge sclk_i or posedge clear_i)
    if (clear_i)
      rises <= 4'h0;
    else
    begin
      rx_byte_o <= {dout_i, rx_byte_o[7:1]};
      rises <= rises + 4'h1;
    end
  // change on fall; line inverts once the byte is over
  always @(negedge sclk_i or posedge clear_i)
    idx <= clear_i ? 4'h0 : rises;
  assign din_o = idx < 4'h8 ? tx_byte_i[idx[2:0]] : ~tx_byte_i[7];
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking testbench for the clocked serial port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  csp_pkg::csp_io_req_type req = '0;
  logic [7:0] rdata, peer_rx;
  logic [7:0] peer_tx = 8'h00;
  logic irq, ck_o, ck_oe, sin, sout, wire_ck;
  logic ext_ck = 1'b1;
  logic peer_clr = 1'b0;
  int fails = 0;
  int n_compared = 0;
  assign wire_ck = ck_oe ? ck_o : ext_ck;
  csp_serial_port i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .io_req_i(req), .io_rdata_o(rdata), .irq_o(irq),
    .serial_clock_pin_i(ext_ck), .serial_clock_pin_o(ck_o), .serial_clock_pin_oe_o(ck_oe),
    .serial_in_pin_i(sin), .serial_out_pin_o(sout));
  csp_peer_model i_peer (.clear_i(peer_clr), .tx_byte_i(peer_tx), .sclk_i(wire_ck), .dout_i(sout),
    .din_o(sin), .rx_byte_o(peer_rx));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk) #1;
    req = {a, w, ~w, d};
    @(posedge ref_clk) #1;
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    chk(rdata, exp);
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && irq !== 1'b1; i++)
      @(posedge ref_clk) #1;
    chk({7'h00, irq}, 8'h01);
  endtask
  task automatic poll_idle(input logic [7:0] mask);
    int i;
    i = 0;
    bus(8'h0a, 1'b0, 8'h00);
    while ((rdata & mask) != 8'h00 && i < 1000)
    begin
      bus(8'h0a, 1'b0, 8'h00);
      i++;
    end
    chk(rdata & mask, 8'h00);
  endtask
  task automatic start(input logic [7:0] d, input logic [7:0] ctl);
    poll_idle(8'h30);
    repeat (1280) @(posedge ref_clk);
    #1 peer_clr = 1'b1;
    #1 peer_clr = 1'b0;
    bus(8'h0b, 1'b1, d);
    bus(8'h0a, 1'b1, ctl & 8'h4f);
    bus(8'h0a, 1'b1, ctl);
  endtask
  task automatic do_reset();
    #1 rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
  endtask
  task automatic t_tx(input logic [2:0] spd, input logic [7:0] d);
    start(d, {5'h0a, spd});
    if (spd == csp_pkg::CSP_SPEED_EXTERNAL)
      repeat (8)
      begin
        #200 ext_ck = 1'b0;
        #200 ext_ck = 1'b1;
      end
    wait_irq(18 * (10 << spd) + 40);
    chk(peer_rx, d);
    rd(8'h0a, {5'h18, spd});
    bus(8'h0b, 1'b0, 8'h00);
    rd(8'h0a, {5'h08, spd});
  endtask
  task automatic t_rx();
    peer_tx = 8'h6a;
    start(8'h00, 8'h60);
    wait_irq(400);
    rd(8'h0b, 8'h6a);
    chk({7'h00, irq}, 8'h00);
    rd(8'h0a, 8'h40);
  endtask
  task automatic t_replace();
    start(8'h0f, 8'h50);
    bus(8'h0b, 1'b1, 8'hf0);
    wait_irq(400);
    chk(peer_rx, 8'hf0);
    bus(8'h0b, 1'b0, 8'h00);
  endtask
  task automatic t_polled();
    peer_tx = 8'ha5;
    start(8'h00, 8'h21);
    poll_idle(8'h20);
    rd(8'h0b, 8'ha5);
    start(8'h5a, 8'h11);
    poll_idle(8'h10);
    chk(peer_rx, 8'h5a);
    chk({7'h00, irq}, 8'h00);
    rd(8'h0a, 8'h81);
  endtask
  task automatic t_abort();
    start(8'h3c, 8'h10);
    repeat (50) @(posedge ref_clk);
    bus(8'h0a, 1'b1, 8'h80);
    rd(8'h0a, 8'h00);
    chk({7'h00, sout}, 8'h01);
    repeat (400) @(posedge ref_clk);
    rd(8'h0a, 8'h00);
  endtask
  task automatic t_reset_mid();
    start(8'h96, 8'h11);
    repeat (30) @(posedge ref_clk);
    do_reset();
    rd(8'h0a, 8'h07);
    chk({7'h00, ck_oe}, 8'h00);
    chk({7'h00, sout}, 8'h01);
    bus(8'h0b, 1'b1, 8'h69);
    do_reset();
    rd(8'h0b, 8'h69);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd(8'h0a, 8'h07);
    rd(8'h0c, 8'h00);
    for (int s = 0; s < 8; s++)
      t_tx(3'(s), 8'h81 ^ 8'(s << 4));
    t_rx();
    t_replace();
    t_polled();
    t_abort();
    t_reset_mid();
    print_verdict();
  end
  initial
  begin
    #1000000;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
